// ---- design/csb_pkg.sv ----
// Shared constants and carriers for the compare, skip and branch unit.
// Assumes one core clock; decode and status logic sit on that clock.
package csb_pkg;

  // Datapath widths
  localparam int PC_W   = 16;
  localparam int OFFS_W = 7;
  localparam int DATA_W = 8;

  // Program counter step figures
  localparam logic [PC_W-1:0] SEQ_STEP     = 16'h0001;
  localparam logic [PC_W-1:0] SKIP_ONE_WRD = 16'h0002;
  localparam logic [PC_W-1:0] SKIP_TWO_WRD = 16'h0003;
  localparam logic [PC_W-1:0] BRANCH_BIAS  = 16'h0001;

  // Status register bit positions
  localparam int FLG_C = 0;
  localparam int FLG_Z = 1;
  localparam int FLG_N = 2;
  localparam int FLG_V = 3;
  localparam int FLG_H = 5;

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_SKIPCNT = 8'h08;
  localparam logic [7:0] OFS_BRCNT   = 8'h0c;
  localparam logic [7:0] OFS_LASTPC  = 8'h10;

  // Control fields and reset value
  localparam int CTRL_CNT_EN = 0;
  localparam int CTRL_CLR    = 1;
  localparam logic CTRL_CNT_EN_RST = 1'b1;

  // Bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Executed operations
  typedef enum logic [3:0] {
    compare_skip_equal,
    compare_immediate,
    skip_reg_bit_clear,
    skip_reg_bit_set,
    skip_io_bit_clear,
    skip_io_bit_set,
    branch_flag_set,
    branch_flag_clear,
    branch_equal,
    branch_not_equal
  } csb_op_t;

  // Decoded instruction from the fetch/decode stage
  typedef struct packed {
    logic                     valid;
    csb_op_t                  op;
    logic [PC_W-1:0]          pc;
    logic [DATA_W-1:0]        rdVal;
    logic [DATA_W-1:0]        rrVal;
    logic [DATA_W-1:0]        imm;
    logic [DATA_W-1:0]        ioVal;
    logic [2:0]               bitSel;
    logic [2:0]               flagSel;
    logic signed [OFFS_W-1:0] offset;
    logic                     nextTwoWord;
  } csb_req_t;

  // Program counter and status update toward the core
  typedef struct packed {
    logic              valid;
    logic [PC_W-1:0]   pcNext;
    logic              taken;
    logic              flagWr;
    logic [DATA_W-1:0] status;
  } csb_rsp_t;

endpackage : csb_pkg

// ---- design/csb_sub_flags.sv ----
// Flag generator for an 8-bit subtraction whose result is discarded.
// Assumes purely combinational use inside the execution unit.
module csb_sub_flags
  import csb_pkg::*;
(
  input  wire logic [DATA_W-1:0] minuend,
  input  wire logic [DATA_W-1:0] subtrahend,
  output logic                   zeroFlg,
  output logic                   negFlg,
  output logic                   ovfFlg,
  output logic                   carryFlg,
  output logic                   halfFlg
);

  logic [DATA_W-1:0] diff;

  // Borrow terms from bit 3 and bit 7
  always_comb
  begin
    diff     = minuend - subtrahend;
    zeroFlg  = (diff == 8'h00);
    negFlg   = diff[7];
    ovfFlg   = (minuend[7] & ~subtrahend[7] & ~diff[7])
             | (~minuend[7] & subtrahend[7] & diff[7]);
    carryFlg = (~minuend[7] & subtrahend[7]) | (subtrahend[7] & diff[7])
             | (diff[7] & ~minuend[7]);
    halfFlg  = (~minuend[3] & subtrahend[3]) | (subtrahend[3] & diff[3])
             | (diff[3] & ~minuend[3]);
  end

endmodule : csb_sub_flags

// ---- design/csb_exec_unit.sv ----
// Execution of compare, skip and conditional branch instructions,
// with an AXI4-Lite register window for counters and last result.
// Assumes decode, register file, I/O space and status share ref_clk.
//
// Local design decisions: the AXI4-Lite register port and the register offsets.

// Notes on behaviour
// - Equal registers skip the next instruction
// - Immediate compare sets Z N V C H
// - Register bit clear skips, flags untouched
// - Register bit set skips, flags untouched
// - I/O bit clear skips, no flags
// - I/O bit set skips, no flags
// - Status bit set branches to PC+k+1
// - Status bit clear branches to PC+k+1
// - Zero flag set branches to PC+k+1
// - Zero flag clear branches to PC+k+1
module csb_exec_unit
  import csb_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              sys_rst,
  input  wire csb_req_t          req,
  input  wire logic [DATA_W-1:0] statusIn,
  output csb_rsp_t               rsp,
  input  wire logic [31:0]       s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [31:0]       s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // Whole state of the unit
  typedef struct packed {
    logic              awFree;
    logic              awSeen;
    logic [7:0]        awAddr;
    logic              awErr;
    logic              wFree;
    logic              wSeen;
    logic [31:0]       wData;
    logic [3:0]        wStrb;
    logic              bValid;
    logic [1:0]        bResp;
    logic              arFree;
    logic              rValid;
    logic [31:0]       rData;
    logic [1:0]        rResp;
    logic              cntEn;
    logic [31:0]       skipCnt;
    logic [31:0]       brCnt;
    logic [PC_W-1:0]   lastPc;
    logic [3:0]        lastOp;
    logic              lastTaken;
    csb_rsp_t          out;
  } csb_state_t;

  csb_state_t st;
  csb_state_t next_st;

  logic subZ;
  logic subN;
  logic subV;
  logic subC;
  logic subH;

  // Flags of the immediate compare
  csb_sub_flags u_flags (
    .minuend    (req.rdVal),
    .subtrahend (req.imm),
    .zeroFlg    (subZ),
    .negFlg     (subN),
    .ovfFlg     (subV),
    .carryFlg   (subC),
    .halfFlg    (subH)
  );

  logic            isSkip;
  logic            isBranch;
  logic            cond;
  logic [PC_W-1:0] skipStep;
  logic [PC_W-1:0] brTarget;
  logic [PC_W-1:0] seqPc;

  // Condition and target for the current instruction
  always_comb
  begin
    isSkip   = 1'b0;
    isBranch = 1'b0;
    cond     = 1'b0;
    seqPc    = req.pc + SEQ_STEP;
    skipStep = req.nextTwoWord ? SKIP_TWO_WRD : SKIP_ONE_WRD;
    brTarget = req.pc + PC_W'(req.offset) + BRANCH_BIAS;
    unique case (req.op)
      compare_skip_equal:
      begin
        isSkip = 1'b1;
        cond   = (req.rdVal == req.rrVal);
      end
      skip_reg_bit_clear:
      begin
        isSkip = 1'b1;
        cond   = ~req.rrVal[req.bitSel];
      end
      skip_reg_bit_set:
      begin
        isSkip = 1'b1;
        cond   = req.rrVal[req.bitSel];
      end
      skip_io_bit_clear:
      begin
        isSkip = 1'b1;
        cond   = ~req.ioVal[req.bitSel];
      end
      skip_io_bit_set:
      begin
        isSkip = 1'b1;
        cond   = req.ioVal[req.bitSel];
      end
      branch_flag_set:
      begin
        isBranch = 1'b1;
        cond     = statusIn[req.flagSel];
      end
      branch_flag_clear:
      begin
        isBranch = 1'b1;
        cond     = ~statusIn[req.flagSel];
      end
      branch_equal:
      begin
        isBranch = 1'b1;
        cond     = statusIn[FLG_Z];
      end
      branch_not_equal:
      begin
        isBranch = 1'b1;
        cond     = ~statusIn[FLG_Z];
      end
      default:
      begin
        cond = 1'b0;
      end
    endcase
  end

  logic [31:0] rdMux;
  logic [1:0]  rdResp;

  // Read decode
  always_comb
  begin
    rdMux  = 32'h0000_0000;
    rdResp = RESP_OKAY;
    unique case (s_axi_araddr[7:0])
      OFS_CTRL:    rdMux = {31'h0000_0000, st.cntEn};
      OFS_STATUS:  rdMux = {27'h000_0000, st.lastTaken, st.lastOp};
      OFS_SKIPCNT: rdMux = st.skipCnt;
      OFS_BRCNT:   rdMux = st.brCnt;
      OFS_LASTPC:  rdMux = {{(32-PC_W){1'b0}}, st.lastPc};
      default:     rdResp = RESP_SLVERR;
    endcase
    if (s_axi_araddr[31:8] != 24'h00_0000)
    begin
      rdMux  = 32'h0000_0000;
      rdResp = RESP_SLVERR;
    end
  end

  logic cntClr;

  // Next state of bus slave, counters and execution result
  always_comb
  begin
    next_st = st;
    cntClr  = 1'b0;

    // Write address and data, taken in either order
    if (s_axi_awvalid && st.awFree)
    begin
      next_st.awSeen = 1'b1;
      next_st.awAddr = s_axi_awaddr[7:0];
      next_st.awErr  = (s_axi_awaddr[31:8] != 24'h00_0000);       // bresp must not move while bvalid
    end
    if (s_axi_wvalid && st.wFree)
    begin
      next_st.wSeen = 1'b1;
      next_st.wData = s_axi_wdata;
      next_st.wStrb = s_axi_wstrb;
    end
    if (st.bValid && s_axi_bready)
    begin
      next_st.bValid = 1'b0;
    end
    if (st.awSeen && st.wSeen && !st.bValid)
    begin
      next_st.awSeen = 1'b0;
      next_st.wSeen  = 1'b0;
      next_st.bValid = 1'b1;
      next_st.bResp  = st.awErr ? RESP_SLVERR : RESP_OKAY;
      if (!st.awErr && st.awAddr == OFS_CTRL)
      begin
        if (st.wStrb[0])
        begin
          next_st.cntEn = st.wData[CTRL_CNT_EN];
          cntClr        = st.wData[CTRL_CLR];
        end
      end
      else if (!st.awErr && st.awAddr != OFS_STATUS
               && st.awAddr != OFS_SKIPCNT && st.awAddr != OFS_BRCNT
               && st.awAddr != OFS_LASTPC)
      begin
        next_st.bResp = RESP_SLVERR;
      end
    end
    next_st.awFree = ~next_st.awSeen;
    next_st.wFree  = ~next_st.wSeen;

    // Read channel
    if (s_axi_arvalid && st.arFree)
    begin
      next_st.rValid = 1'b1;
      next_st.rData  = rdMux;
      next_st.rResp  = rdResp;
    end
    else if (st.rValid && s_axi_rready)
    begin
      next_st.rValid = 1'b0;
    end
    next_st.arFree = ~next_st.rValid;

    // Counters; an event in the clearing cycle still counts
    if (cntClr)
    begin
      next_st.skipCnt = 32'h0000_0000;
      next_st.brCnt   = 32'h0000_0000;
    end

    // Execution result, one cycle after the request
    next_st.out.valid  = req.valid;
    next_st.out.taken  = 1'b0;
    next_st.out.flagWr = 1'b0;
    next_st.out.status = statusIn;
    next_st.out.pcNext = seqPc;
    if (req.valid)
    begin
      next_st.lastPc    = req.pc;
      next_st.lastOp    = req.op;
      next_st.lastTaken = cond;
      if (isSkip && cond)
      begin
        next_st.out.pcNext = req.pc + skipStep;
        next_st.out.taken  = 1'b1;
      end
      else if (isBranch && cond)
      begin
        next_st.out.pcNext = brTarget;
        next_st.out.taken  = 1'b1;
      end
      if (req.op == compare_immediate)
      begin
        next_st.out.flagWr        = 1'b1;
        next_st.out.status[FLG_Z] = subZ;
        next_st.out.status[FLG_N] = subN;
        next_st.out.status[FLG_V] = subV;
        next_st.out.status[FLG_C] = subC;
        next_st.out.status[FLG_H] = subH;
      end
      if (st.cntEn && isSkip && cond)
      begin
        next_st.skipCnt = next_st.skipCnt + 32'h0000_0001;
      end
      if (st.cntEn && isBranch && cond)
      begin
        next_st.brCnt = next_st.brCnt + 32'h0000_0001;
      end
    end
  end

  // State register
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      st        <= '0;
      st.awFree <= 1'b1;
      st.wFree  <= 1'b1;
      st.arFree <= 1'b1;
      st.cntEn  <= CTRL_CNT_EN_RST;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Outputs straight from the state register
  assign rsp           = st.out;
  assign s_axi_awready = st.awFree;
  assign s_axi_wready  = st.wFree;
  assign s_axi_bvalid  = st.bValid;
  assign s_axi_bresp   = st.bResp;
  assign s_axi_arready = st.arFree;
  assign s_axi_rvalid  = st.rValid;
  assign s_axi_rdata   = st.rData;
  assign s_axi_rresp   = st.rResp;

endmodule : csb_exec_unit

// ---- verification/csb_exec_checker.sv ----
// Concurrent checks on the compare, skip and branch unit.
// Bound to csb_exec_unit from the bench top; one clock, reset high.
module csb_exec_checker
  import csb_pkg::*;
(
  input wire logic          ref_clk,
  input wire logic          sys_rst,
  input wire csb_req_t      req,
  input wire logic [7:0]    statusIn,
  input wire csb_rsp_t      rsp,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic          s_axi_rvalid
);
  timeunit 1ns;
  timeprecision 1ps;

  logic            hit;
  logic            isSkip;
  logic            isBr;
  logic [PC_W-1:0] skPc;
  logic [PC_W-1:0] brPc;
  logic [7:0]      dif;
  logic [7:0]      cmpSt;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);

  // Condition, targets and compare flags of the request
  always_comb
  begin
    isSkip = req.op == compare_skip_equal || (req.op >= skip_reg_bit_clear && req.op <= skip_io_bit_set);
    isBr = req.op >= branch_flag_set && req.op <= branch_not_equal;
    case (req.op)
      compare_skip_equal: hit = req.rdVal == req.rrVal;
      skip_reg_bit_clear: hit = !req.rrVal[req.bitSel];
      skip_reg_bit_set:   hit = req.rrVal[req.bitSel];
      skip_io_bit_clear:  hit = !req.ioVal[req.bitSel];
      skip_io_bit_set:    hit = req.ioVal[req.bitSel];
      branch_flag_set:    hit = statusIn[req.flagSel];
      branch_flag_clear:  hit = !statusIn[req.flagSel];
      branch_equal:       hit = statusIn[FLG_Z];
      branch_not_equal:   hit = !statusIn[FLG_Z];
      default:            hit = 1'b0;
    endcase
    skPc = req.pc + (req.nextTwoWord ? SKIP_TWO_WRD : SKIP_ONE_WRD);
    brPc = req.pc + {{(PC_W-OFFS_W){req.offset[OFFS_W-1]}}, req.offset} + BRANCH_BIAS;
    dif = req.rdVal - req.imm;
    cmpSt = statusIn;
    cmpSt[FLG_Z] = dif == 8'h00;
    cmpSt[FLG_N] = dif[7];
    cmpSt[FLG_V] = (req.rdVal[7] ^ req.imm[7]) & (dif[7] ^ req.rdVal[7]);
    cmpSt[FLG_C] = req.rdVal < req.imm;
    cmpSt[FLG_H] = req.rdVal[3:0] < req.imm[3:0];
  end

  a_answer_next: assert property (req.valid |=> rsp.valid)
    else $error("no answer after request");
  a_no_extra: assert property (!req.valid |=> !rsp.valid)
    else $error("answer without request");
  a_skip_step: assert property (req.valid && isSkip && hit |=> rsp.taken && rsp.pcNext == $past(skPc))
    else $error("skip target wrong");
  a_branch_jump: assert property (req.valid && isBr && hit |=> rsp.taken && rsp.pcNext == $past(brPc))
    else $error("branch target wrong");
  a_fall_through: assert property (req.valid && !hit |=> !rsp.taken && rsp.pcNext == $past(req.pc) + SEQ_STEP)
    else $error("sequential step wrong");
  a_flags_kept: assert property (req.valid && req.op != compare_immediate |=> !rsp.flagWr && rsp.status == $past(statusIn))
    else $error("flags changed");
  a_cmp_flags: assert property (req.valid && req.op == compare_immediate |=> rsp.flagWr && rsp.status == $past(cmpSt))
    else $error("compare flags wrong");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
  a_read_busy: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
endmodule : csb_exec_checker

// ---- verification/csb_core_model.sv ----
// Core side model: holds the status register seen by the unit.
// Bench preloads it; compare results are written back on answer.
module csb_core_model
  import csb_pkg::*;
(
  input wire logic        ref_clk,
  input wire logic        sys_rst,
  input wire csb_rsp_t    rsp,
  input wire logic        ldEn,
  input wire logic [7:0]  ldVal,
  output logic [7:0]      statusIn
);
  timeunit 1ns;
  timeprecision 1ps;

  // Status register update
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
      statusIn <= 8'h00;
    else if (ldEn)
      statusIn <= ldVal;
    else if (rsp.valid && rsp.flagWr)
      statusIn <= rsp.status;
  end
endmodule : csb_core_model

// ---- verification/tb_compare_skip_branch_exec.sv ----
// Testbench for the compare, skip and branch unit.
// Drives decoded requests and AXI4-Lite; core model holds status.
module tb_compare_skip_branch_exec
  import csb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  csb_req_t    req = '0;
  csb_req_t    nx;
  csb_rsp_t    rsp;
  logic [7:0]  statusIn;
  logic [7:0]  curSt = 8'h00;
  logic        ldEn = 1'b0;
  logic [7:0]  ldVal = 8'h00;
  logic [31:0] awAddr = '0, wData = '0, arAddr = '0, rData;
  logic        awValid = 0, wValid = 0, bReady = 0, arValid = 0, rReady = 0;
  logic [3:0]  wStrb = 4'hf;
  logic        awReady, wReady, bValid, arReady, rValid;
  logic [1:0]  bResp, rResp;
  int          error_cnt = 0;
  int          comparisons = 0;

  // Core clock
  always #5 ref_clk = ~ref_clk;

  csb_exec_unit i_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req), .statusIn(statusIn),
    .rsp(rsp), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
    .s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
    .s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
    .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
    .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady));

  csb_core_model i_core (.ref_clk(ref_clk), .sys_rst(sys_rst), .rsp(rsp), .ldEn(ldEn),
    .ldVal(ldVal), .statusIn(statusIn));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic stop_test;
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : stop_test

  task automatic set_st(input logic [7:0] v);
    @(posedge ref_clk);
    ldEn <= 1'b1;
    ldVal <= v;
    @(posedge ref_clk);
    ldEn <= 1'b0;
    curSt = v;
  endtask : set_st

  // One request, answer judged the cycle after
  task automatic exec_chk(input logic [15:0] ePc, input logic eTk, input logic eWr,
                          input logic [7:0] eSt);
    @(posedge ref_clk);
    nx.valid = 1'b1;
    req <= nx;
    @(posedge ref_clk);
    req.valid <= 1'b0;
    #1;
    check("valid", rsp.valid, 1'b1);
    check("pcNext", rsp.pcNext, ePc);
    check("taken", rsp.taken, eTk);
    check("flagWr", rsp.flagWr, eWr);
    check("status", rsp.status, eSt);
  endtask : exec_chk

  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d, output logic [1:0] r);
    logic awDone;
    logic wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    @(posedge ref_clk);
    awAddr <= a;
    wData <= d;
    awValid <= 1'b1;
    wValid <= 1'b1;
    bReady <= 1'b1;
    while (!(awDone && wDone))
    begin
      @(posedge ref_clk);
      if (awReady && !awDone)
      begin
        awDone = 1'b1;
        awValid <= 1'b0;
      end
      if (wReady && !wDone)
      begin
        wDone = 1'b1;
        wValid <= 1'b0;
      end
    end
    while (!bValid) @(posedge ref_clk);
    r = bResp;
    bReady <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [31:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    arAddr <= a;
    arValid <= 1'b1;
    rReady <= 1'b1;
    do @(posedge ref_clk); while (!arReady);
    arValid <= 1'b0;
    do @(posedge ref_clk); while (!rValid);
    d = rData;
    r = rResp;
    rReady <= 1'b0;
  endtask : axi_rd

  // All skip kinds, hit and miss, one and two words, across the wrap
  task automatic t_skip;
    logic       hit;
    logic [7:0] v;
    set_st(8'h2b);
    for (int i = 0; i < 5; i++)
      for (int h = 0; h < 4; h++)
      begin
        hit = h[0];
        nx = '0;
        nx.op = (i == 0) ? compare_skip_equal : csb_op_t'(i + 1);
        nx.pc = 16'hfffe;
        nx.bitSel = 3'(i + 3);
        nx.nextTwoWord = h[1];
        v = 8'h01 << nx.bitSel;
        if (hit ^ (i == 2 || i == 4)) v = ~v;
        nx.rrVal = (i > 2) ? ~v : v;
        nx.ioVal = ~nx.rrVal;
        if (i == 0) nx.rdVal = hit ? nx.rrVal : ~nx.rrVal;
        exec_chk(hit ? (h[1] ? 16'h0001 : 16'h0000) : 16'hffff, hit, 1'b0, curSt);
      end
  endtask : t_skip

  // All branch kinds, hit and miss, extreme offsets
  task automatic t_branch;
    logic       hit;
    logic [7:0] v;
    for (int i = 0; i < 4; i++)
      for (int h = 0; h < 4; h++)
      begin
        hit = h[0];
        v = 8'h01 << ((i < 2) ? i + 4 : FLG_Z);
        if (hit ^ (i % 2 == 0)) v = ~v;
        set_st(v);
        nx = '0;
        nx.op = csb_op_t'(i + 6);
        nx.pc = 16'h0040;
        nx.flagSel = 3'(i + 4);
        nx.offset = h[1] ? 7'h40 : 7'h3f;
        exec_chk(hit ? (h[1] ? 16'h0001 : 16'h0080) : 16'h0041, hit, 1'b0, curSt);
      end
  endtask : t_branch

  // Immediate compares, then a branch on the written back zero flag
  task automatic t_cmp;
    logic [7:0] a [4] = '{8'h00, 8'h80, 8'h7f, 8'h3c};
    logic [7:0] b [4] = '{8'h01, 8'h01, 8'hff, 8'h3c};
    logic [7:0] e;
    logic [7:0] d;
    set_st(8'hd0);
    for (int i = 0; i < 4; i++)
    begin
      d = a[i] - b[i];
      e = curSt;
      e[FLG_Z] = d == 8'h00;
      e[FLG_N] = d[7];
      e[FLG_V] = (a[i][7] != b[i][7]) && (d[7] != a[i][7]);
      e[FLG_C] = a[i] < b[i];
      e[FLG_H] = a[i][3:0] < b[i][3:0];
      nx = '0;
      nx.op = compare_immediate;
      nx.pc = 16'h0200;
      nx.rdVal = a[i];
      nx.imm = b[i];
      nx.rrVal = ~b[i];
      exec_chk(16'h0201, 1'b0, 1'b1, e);
      curSt = e;
    end
    nx = '0;
    nx.op = branch_equal;
    nx.pc = 16'h0010;
    nx.offset = 7'h7e;
    exec_chk(16'h000f, 1'b1, 1'b0, curSt);
  endtask : t_cmp

  // Register window: reset value, unmapped read refusal, accepted read-only write, counters and last result
  task automatic t_regs;
    logic [31:0] d;
    logic [1:0]  r;
    axi_rd(32'h0, d, r);
    check("ctrl", {d[29:0], r}, {30'h1, RESP_OKAY});
    axi_rd(32'h40, d, r);
    check("unmapped", {d[29:0], r}, {30'h0, RESP_SLVERR});
    axi_wr(32'h08, 32'hffff, r);
    check("ro write", r, RESP_OKAY);
    axi_rd(32'h08, d, r);
    check("skips before clear", d, 32'ha);
    axi_rd(32'h0c, d, r);
    check("branches", d, 32'h9);
    axi_wr(32'h0, 32'h3, r);
    check("clear", r, RESP_OKAY);
    nx = '0;
    nx.pc = 16'h0123;
    exec_chk(16'h0125, 1'b1, 1'b0, curSt);
    axi_rd(32'h08, d, r);
    check("skips", d, 32'h1);
    axi_rd(32'h04, d, r);
    check("last op", d, 32'h10);
    axi_rd(32'h10, d, r);
    check("last pc", d, 32'h0123);
    nx.op = csb_op_t'(4'hf);
    exec_chk(16'h0124, 1'b0, 1'b0, curSt);
    nx.op = compare_skip_equal;
    wStrb <= 4'he;
    axi_wr(32'h0, 32'h0, r);
    axi_rd(32'h0, d, r);
    check("ctrl strobe", d, 32'h1);
    wStrb <= 4'hf;
    axi_wr(32'h0, 32'h0, r);
    axi_rd(32'h0, d, r);
    check("ctrl off", d, 32'h0);
    exec_chk(16'h0125, 1'b1, 1'b0, curSt);
    axi_rd(32'h08, d, r);
    check("skips held", d, 32'h1);
  endtask : t_regs

  // Reset in mid-run restores the register window
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    sys_rst <= 1'b0;
    axi_rd(32'h0, d, r);
    check("ctrl after reset", d, 32'h1);
    axi_rd(32'h08, d, r);
    check("skips after reset", d, 32'h0);
  endtask : t_reset

  // Main sequence
  initial
  begin
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_skip();
    t_branch();
    t_cmp();
    t_regs();
    t_reset();
    stop_test();
  end

  // Watchdog
  initial
  begin
    repeat (5000) @(posedge ref_clk);
    error_cnt++;
    stop_test();
  end
endmodule : tb_compare_skip_branch_exec

bind csb_exec_unit csb_exec_checker i_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .req(req),
  .statusIn(statusIn), .rsp(rsp), .s_axi_arvalid(s_axi_arvalid),
  .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid));
